/* File: hdl/power_stage_block_event_logic.sv */
/*
 * four-stage power protection: blocking, definite-time supervision,
 * events, occurrence counters and a twelve-entry fault record store
 * assumes block_in, meas_power and time_stamp synchronous to aclk
 */
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module power_stage_block_event_logic
    import pwr_pkg::*;
#(
    parameter int CYCLE_CLKS = CYCLE_CLKS_DEF
)(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [AW-1:0]       awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [AW-1:0]       araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire logic [NSTAGE-1:0]   block_in,
    input  wire logic [NSTAGE*PW-1:0] meas_power,
    input  wire logic [31:0]         time_stamp,
    output logic [NSTAGE-1:0]        start_out,
    output logic [NSTAGE-1:0]        trip_out,
    output logic [NSTAGE-1:0]        blocked_out,
    output logic                     event_valid,
    output logic [1:0]               event_stage,
    output logic [NEV-1:0]           event_flags,
    output logic [31:0]              event_time
);

    function automatic logic [2:0] flags(input stage_e s);
        flags = 3'h0;
        flags[FL_START] = (s == ST_START) || (s == ST_TRIP);
        flags[FL_TRIP]  = (s == ST_TRIP);
        flags[FL_BLOCK] = (s == ST_BLOCK);
    endfunction : flags

    function automatic logic mapped(input logic [AW-1:0] a);
        mapped = (a[1:0] == 2'h0) &&
                 (a <= A_REC_E || (a >= A_CNT0 && a < A_CNTEND));
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
        merge = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) merge[b*8 +: 8] = n[b*8 +: 8];
        end
    endfunction : merge

    ////////////////////////////////////////////////////////////////////
    // processing cycle tick and measurement history

    logic [17:0]         cyc_reg;
    logic                tick;
    logic signed [PW-1:0] hist [NSTAGE][HIST_LEN];

    // free-running processing cycle counter
    always_ff @(posedge aclk) begin
        if (!aresetn) cyc_reg <= 18'h00000;
        else if (tick) cyc_reg <= 18'h00000;
        else cyc_reg <= cyc_reg + 18'h00001;
    end
    assign tick = (cyc_reg == 18'(CYCLE_CLKS - 1));

    // per-stage delay line of one sample per cycle
    generate
        for (genvar g = 0; g < NSTAGE; g++) begin : g_hist
            always_ff @(posedge aclk) begin
                if (tick) begin
                    hist[g][0] <= meas_power[g*PW +: PW];
                    for (int k = 1; k < HIST_LEN; k++) begin
                        hist[g][k] <= hist[g][k-1];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // register file and axi4-lite slave

    logic [CTRL_W-1:0] ctrl_reg,   ctrl_next;
    logic [PW-1:0]     pickup_reg, pickup_next;
    logic [TW-1:0]     opdly_reg,  opdly_next;
    logic [TW-1:0]     reldly_reg, reldly_next;
    logic [2:0]        grp_reg,    grp_next;
    logic [3:0]        recsel_reg, recsel_next;
    logic [NSTAGE-1:0] clr_reg,    clr_next;
    logic              aw_ok_reg,  aw_ok_next;
    logic              w_ok_reg,   w_ok_next;
    logic [AW-1:0]     waddr_reg,  waddr_next;
    logic [31:0]       wdat_reg,   wdat_next;
    logic [3:0]        wstb_reg,   wstb_next;
    logic              bvalid_reg, bvalid_next;
    logic [1:0]        bresp_reg,  bresp_next;
    logic              arrdy_reg,  arrdy_next;
    logic              rvalid_reg, rvalid_next;
    logic [1:0]        rresp_reg,  rresp_next;
    logic [31:0]       rdata_reg,  rdata_next;
    logic [31:0]       rd_val;
    logic [4:0]        ri;

    // record store and counters, driven further down
    logic [31:0]       rec_time [NREC];
    logic [PW-1:0]     rec_pre20 [NREC];
    logic [PW-1:0]     rec_fault [NREC];
    logic [PW-1:0]     rec_pre200 [NREC];
    logic [RW-1:0]     rec_rem [NREC];
    logic [7:0]        rec_info [NREC];
    logic [3:0]        wptr_reg, wptr_next;
    logic [3:0]        rcnt_reg, rcnt_next;
    logic [CW-1:0]     cnt_reg [NSTAGE][3];
    logic [CW-1:0]     cnt_next [NSTAGE][3];

    // read mux, record index counts back from the newest
    always_comb begin
        ri = 5'(wptr_reg) + 5'(NREC - 1) - 5'(recsel_reg);
        if (ri >= 5'(NREC)) ri = ri - 5'(NREC);
        rd_val = 32'h0000_0000;
        case (araddr)
            A_CTRL:   rd_val = 32'(ctrl_reg);
            A_PICKUP: rd_val = 32'(pickup_reg);
            A_OPDLY:  rd_val = 32'(opdly_reg);
            A_RELDLY: rd_val = 32'(reldly_reg);
            A_SETGRP: rd_val = 32'(grp_reg);
            A_STATUS: rd_val = {20'h00000, blocked_out, trip_out, start_out};
            A_RECSEL: rd_val = {24'h000000, rcnt_reg, recsel_reg};
            default:  rd_val = 32'h0000_0000;
        endcase
        if (recsel_reg < rcnt_reg) begin
            case (araddr)
                A_REC_A: rd_val = rec_time[ri[3:0]];
                A_REC_B: rd_val = {rec_pre20[ri[3:0]], rec_fault[ri[3:0]]};
                A_REC_C: rd_val = 32'(rec_pre200[ri[3:0]]);
                A_REC_D: rd_val = 32'(rec_info[ri[3:0]]);
                A_REC_E: rd_val = 32'(rec_rem[ri[3:0]]);
                default: ;
            endcase
        end
        if (araddr >= A_CNT0 && araddr < A_CNTEND) begin
            rd_val = {2'h0, cnt_reg[araddr[3:2]][FL_BLOCK],
                      cnt_reg[araddr[3:2]][FL_TRIP],
                      cnt_reg[araddr[3:2]][FL_START]};
        end
    end

    // bus handshakes and register writes
    always_comb begin
        ctrl_next   = ctrl_reg;
        pickup_next = pickup_reg;
        opdly_next  = opdly_reg;
        reldly_next = reldly_reg;
        grp_next    = grp_reg;
        recsel_next = recsel_reg;
        clr_next    = '0;
        aw_ok_next  = aw_ok_reg | awvalid;
        w_ok_next   = w_ok_reg | wvalid;
        waddr_next  = aw_ok_reg ? waddr_reg : awaddr;
        wdat_next   = w_ok_reg ? wdat_reg : wdata;
        wstb_next   = w_ok_reg ? wstb_reg : wstrb;
        bvalid_next = bvalid_reg & ~bready;
        bresp_next  = bresp_reg;
        arrdy_next  = arrdy_reg;
        rvalid_next = rvalid_reg;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        if (aw_ok_reg && w_ok_reg && !bvalid_reg) begin
            aw_ok_next  = 1'b0;
            w_ok_next   = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
            case (waddr_reg)
                A_CTRL:   ctrl_next = CTRL_W'(merge(32'(ctrl_reg),
                                      wdat_reg, wstb_reg));
                A_PICKUP: pickup_next = PW'(merge(32'(pickup_reg),
                                        wdat_reg, wstb_reg));
                A_OPDLY:  opdly_next = TW'(merge(32'(opdly_reg),
                                       wdat_reg, wstb_reg));
                A_RELDLY: reldly_next = TW'(merge(32'(reldly_reg),
                                        wdat_reg, wstb_reg));
                A_SETGRP: if (wstb_reg[0]) grp_next = wdat_reg[2:0];
                A_CNTCLR: if (wstb_reg[0]) clr_next = wdat_reg[3:0];
                A_RECSEL: if (wstb_reg[0] && wdat_reg[3:0] < 4'(NREC))
                              recsel_next = wdat_reg[3:0];
                default:  ;
            endcase
        end
        if (arvalid && arrdy_reg) begin
            arrdy_next  = 1'b0;
            rvalid_next = 1'b1;
            rdata_next  = rd_val;
            rresp_next  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
            arrdy_next  = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= CTRL_RST;
            pickup_reg <= PICKUP_RST;
            opdly_reg  <= OPDLY_RST;
            reldly_reg <= RELDLY_RST;
            grp_reg    <= 3'h0;
            recsel_reg <= 4'h0;
            clr_reg    <= '0;
            aw_ok_reg  <= 1'b0;
            w_ok_reg   <= 1'b0;
            waddr_reg  <= '0;
            wdat_reg   <= 32'h0000_0000;
            wstb_reg   <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
            arrdy_reg  <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            ctrl_reg   <= ctrl_next;
            pickup_reg <= pickup_next;
            opdly_reg  <= opdly_next;
            reldly_reg <= reldly_next;
            grp_reg    <= grp_next;
            recsel_reg <= recsel_next;
            clr_reg    <= clr_next;
            aw_ok_reg  <= aw_ok_next;
            w_ok_reg   <= w_ok_next;
            waddr_reg  <= waddr_next;
            wdat_reg   <= wdat_next;
            wstb_reg   <= wstb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg  <= bresp_next;
            arrdy_reg  <= arrdy_next;
            rvalid_reg <= rvalid_next;
            rresp_reg  <= rresp_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign awready = ~aw_ok_reg;
    assign wready  = ~w_ok_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign arready = arrdy_reg;
    assign rvalid  = rvalid_reg;
    assign rresp   = rresp_reg;
    assign rdata   = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // stage sweep: one stage handled per clock after each tick

    stage_e            st_reg [NSTAGE];
    stage_e            st_next [NSTAGE];
    logic [TW-1:0]     tmr_reg [NSTAGE];
    logic [TW-1:0]     tmr_next [NSTAGE];
    logic [TW-1:0]     rtm_reg [NSTAGE];
    logic [TW-1:0]     rtm_next [NSTAGE];
    logic [NSTAGE-1:0] pk_reg,   pk_next;
    logic [NSTAGE-1:0] blk_reg,  blk_next;
    logic [2:0]        sw_reg,   sw_next;
    logic [NSTAGE-1:0] so_next,  to_next, bo_next;
    logic              ev_next;
    logic [NEV-1:0]    evf_next;
    logic [1:0]        evs_next;
    logic [31:0]       evt_next;
    logic              rec_we;
    logic [7:0]        info_w;
    logic [RW-1:0]     rem_w;
    logic [1:0]        idx;
    logic signed [PW-1:0] m, s;
    logic signed [23:0] m_sc, s_sc;
    logic              pk, blk;
    logic [2:0]        f_old, f_new, rise, fall;
    logic [2:0]        f_out;

    always_comb begin
        st_next  = st_reg;
        tmr_next = tmr_reg;
        rtm_next = rtm_reg;
        pk_next  = pk_reg;
        cnt_next = cnt_reg;
        blk_next = tick ? block_in : blk_reg;
        sw_next  = tick ? 3'h0 :
                   (sw_reg < 3'(NSTAGE) ? sw_reg + 3'h1 : sw_reg);
        idx      = sw_reg[1:0];
        m        = hist[idx][0];
        s        = pickup_reg;
        m_sc     = 24'(m) * 24'(R_BASE);
        s_sc     = 24'(s) * 24'(ctrl_reg[C_UNDER] ? R_UNDER : R_OVER);
        blk      = blk_reg[idx];
        ev_next  = 1'b0;
        evf_next = '0;
        evs_next = idx;
        evt_next = time_stamp;
        rec_we   = 1'b0;
        info_w   = 8'h00;
        rem_w    = '0;
        rise     = 3'h0;
        fall     = 3'h0;
        f_out    = 3'h0;
        f_old    = flags(st_reg[idx]);
        f_new    = f_old;
        pk       = pk_reg[idx];
        for (int i = 0; i < NSTAGE; i++) begin
            if (clr_reg[i]) begin
                for (int k = 0; k < 3; k++) cnt_next[i][k] = '0;
            end
        end
        if (sw_reg < 3'(NSTAGE)) begin
            // hysteresis on the release side only
            if (ctrl_reg[C_UNDER]) pk = pk ? (m_sc < s_sc) : (m < s);
            else pk = pk ? (m_sc > s_sc) : (m > s);
            pk_next[idx] = pk;
            case (st_reg[idx])
                ST_IDLE: if (pk) begin
                    if (blk) st_next[idx] = ST_BLOCK;
                    else begin
                        st_next[idx]  = ST_START;
                        tmr_next[idx] = '0;
                    end
                end
                ST_START: if (blk || !pk) begin
                    st_next[idx]  = ST_REL;
                    rtm_next[idx] = '0;
                end else if (tmr_reg[idx] + 16'h0001 >= opdly_reg) begin
                    st_next[idx]  = ST_TRIP;
                    tmr_next[idx] = opdly_reg;
                end else tmr_next[idx] = tmr_reg[idx] + 16'h0001;
                ST_REL: if (pk && !blk) st_next[idx] = ST_START;
                else if (rtm_reg[idx] + 16'h0001 >= reldly_reg) begin
                    st_next[idx]  = ST_IDLE;
                    tmr_next[idx] = '0;
                end else rtm_next[idx] = rtm_reg[idx] + 16'h0001;
                ST_TRIP: if (!pk) begin
                    st_next[idx]  = ST_IDLE;
                    tmr_next[idx] = '0;
                end
                ST_BLOCK: if (!pk) st_next[idx] = ST_IDLE;
                else if (!blk) begin
                    st_next[idx]  = ST_START;
                    tmr_next[idx] = '0;
                end
                default: st_next[idx] = ST_IDLE;
            endcase
            if (ctrl_reg[C_FEN]) begin
                case (force_e'(ctrl_reg[C_FVAL +: 2]))
                    F_START: st_next[idx] = ST_START;
                    F_TRIP:  st_next[idx] = ST_TRIP;
                    F_BLOCK: st_next[idx] = ST_BLOCK;
                    default: st_next[idx] = ST_IDLE;
                endcase
                tmr_next[idx] = '0;
            end
            f_new = flags(st_next[idx]);
            rise  = f_new & ~f_old;
            fall  = f_old & ~f_new;
            for (int k = 0; k < 3; k++) begin
                cnt_next[idx][k] = cnt_next[idx][k] + CW'(rise[k]);
                evf_next[2*k]    = rise[k] & ctrl_reg[C_SON];
                evf_next[2*k+1]  = fall[k] & ctrl_reg[C_SOFF];
            end
            ev_next = |evf_next;
            rec_we  = |rise;
            rem_w   = RW'((opdly_reg - tmr_next[idx]) * CYCLE_MS);
            info_w  = {grp_reg, idx, rise[FL_TRIP] ? EV_TRIP_ON :
                       rise[FL_START] ? EV_START_ON : EV_BLOCK_ON};
        end
        for (int i = 0; i < NSTAGE; i++) begin
            f_out      = flags(st_next[i]);
            so_next[i] = f_out[FL_START];
            to_next[i] = f_out[FL_TRIP];
            bo_next[i] = f_out[FL_BLOCK];
        end
        wptr_next = wptr_reg;
        rcnt_next = rcnt_reg;
        if (rec_we) begin
            wptr_next = (wptr_reg == 4'(NREC - 1)) ? 4'h0 : wptr_reg + 4'h1;
            if (rcnt_reg < 4'(NREC)) rcnt_next = rcnt_reg + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NSTAGE; i++) begin
                st_reg[i]  <= ST_IDLE;
                tmr_reg[i] <= '0;
                rtm_reg[i] <= '0;
                for (int k = 0; k < 3; k++) cnt_reg[i][k] <= '0;
            end
            pk_reg      <= '0;
            blk_reg     <= '0;
            sw_reg      <= 3'(NSTAGE);
            start_out   <= '0;
            trip_out    <= '0;
            blocked_out <= '0;
            event_valid <= 1'b0;
            event_flags <= '0;
            event_stage <= 2'h0;
            event_time  <= 32'h0000_0000;
            wptr_reg    <= 4'h0;
            rcnt_reg    <= 4'h0;
        end else begin
            st_reg      <= st_next;
            tmr_reg     <= tmr_next;
            rtm_reg     <= rtm_next;
            cnt_reg     <= cnt_next;
            pk_reg      <= pk_next;
            blk_reg     <= blk_next;
            sw_reg      <= sw_next;
            start_out   <= so_next;
            trip_out    <= to_next;
            blocked_out <= bo_next;
            event_valid <= ev_next;
            event_flags <= evf_next;
            event_stage <= evs_next;
            event_time  <= evt_next;
            wptr_reg    <= wptr_next;
            rcnt_reg    <= rcnt_next;
        end
    end

    // fault record ring, oldest slot overwritten when full
    always_ff @(posedge aclk) begin
        if (rec_we) begin
            rec_time[wptr_reg]   <= time_stamp;
            rec_pre20[wptr_reg]  <= hist[idx][HIST_TRIG];
            rec_fault[wptr_reg]  <= m;
            rec_pre200[wptr_reg] <= hist[idx][HIST_LEN-1];
            rec_rem[wptr_reg]    <= rem_w;
            rec_info[wptr_reg]   <= info_w;
        end
    end

endmodule : power_stage_block_event_logic

/* File: hdl/pwr_pkg.sv */
/*
 * constants, offsets and types for the power stage event logic
 * assumes a 40 MHz aclk and a 5 ms processing cycle
 */
package pwr_pkg;
    localparam int NSTAGE = 4;
    localparam int NREC   = 12;
    localparam int AW     = 8;
    localparam int PW     = 16;   // power sample width, signed
    localparam int TW     = 16;   // timer width, processing cycles
    localparam int CW     = 10;   // occurrence counter width
    localparam int RW     = 21;   // remaining time width, ms
    // register offsets
    localparam logic [AW-1:0] A_CTRL   = 8'h00;
    localparam logic [AW-1:0] A_PICKUP = 8'h04;
    localparam logic [AW-1:0] A_OPDLY  = 8'h08;
    localparam logic [AW-1:0] A_RELDLY = 8'h0C;
    localparam logic [AW-1:0] A_SETGRP = 8'h10;
    localparam logic [AW-1:0] A_STATUS = 8'h14;
    localparam logic [AW-1:0] A_CNTCLR = 8'h18;
    localparam logic [AW-1:0] A_RECSEL = 8'h1C;
    localparam logic [AW-1:0] A_REC_A  = 8'h20;
    localparam logic [AW-1:0] A_REC_B  = 8'h24;
    localparam logic [AW-1:0] A_REC_C  = 8'h28;
    localparam logic [AW-1:0] A_REC_D  = 8'h2C;
    localparam logic [AW-1:0] A_REC_E  = 8'h30;
    localparam logic [AW-1:0] A_CNT0   = 8'h40;
    localparam logic [AW-1:0] A_CNTEND = 8'h50;
    // control fields
    localparam int C_FEN   = 0;
    localparam int C_FVAL  = 1;
    localparam int C_UNDER = 3;
    localparam int C_SON   = 4;
    localparam int C_SOFF  = 5;
    localparam int CTRL_W  = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST   = 6'h30;
    localparam logic [PW-1:0]     PICKUP_RST = 16'h0000;
    localparam logic [TW-1:0]     OPDLY_RST  = 16'h0014;
    localparam logic [TW-1:0]     RELDLY_RST = 16'h0004;
    // timing
    localparam int CLK_NS         = 25;
    localparam int NS_PER_MS      = 1000000;
    localparam int CYCLE_MS       = 5;
    localparam int CYCLE_CLKS_DEF = CYCLE_MS * NS_PER_MS / CLK_NS;
    localparam int PRE_TRIG_MS    = 20;
    localparam int PRE_FAULT_MS   = 200;
    localparam int HIST_TRIG      = PRE_TRIG_MS / CYCLE_MS;
    localparam int HIST_LEN       = PRE_FAULT_MS / CYCLE_MS + 1;
    // release ratios in percent
    localparam logic signed [7:0] R_BASE  = 8'sh64;
    localparam logic signed [7:0] R_OVER  = 8'sh61;
    localparam logic signed [7:0] R_UNDER = 8'sh67;
    // status flag bits
    localparam int FL_START = 0;
    localparam int FL_TRIP  = 1;
    localparam int FL_BLOCK = 2;
    // event indices
    localparam logic [2:0] EV_START_ON = 3'h0;
    localparam logic [2:0] EV_TRIP_ON  = 3'h2;
    localparam logic [2:0] EV_BLOCK_ON = 3'h4;
    localparam int NEV = 6;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_TRIP  = 3'b010,
        ST_BLOCK = 3'b011,
        ST_REL   = 3'b100
    } stage_e;

    typedef enum logic [1:0] {
        F_NORMAL = 2'b00,
        F_START  = 2'b01,
        F_TRIP   = 2'b10,
        F_BLOCK  = 2'b11
    } force_e;
endpackage : pwr_pkg

/* File: dv/pwr_props.sv */
/* checker on the power stage ports
   assumes one aclk domain, bound to power_stage_block_event_logic below */
`timescale 1ns/1ps
module pwr_props
    import pwr_pkg::*;
(
    input wire logic              aclk, aresetn, awready, wready,
    input wire logic              bvalid, bready, arvalid, arready,
    input wire logic              rvalid, rready, event_valid,
    input wire logic [31:0]       rdata,
    input wire logic [NSTAGE-1:0] start_out, trip_out, blocked_out,
    input wire logic [1:0]        event_stage,
    input wire logic [NEV-1:0]    event_flags
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////
    bus_bhold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("write answer dropped early");
    bus_rhold_a: assert property (rvalid && !rready |=>
        rvalid && $stable(rdata)) else $error("read answer moved");
    bus_rans_a: assert property (arvalid && arready |=>
        rvalid && !arready) else $error("read not answered");
    bus_free_a: assert property (bvalid |-> awready && wready)
        else $error("write channels not free");
    trip_start_a: assert property ((trip_out & ~start_out) == 0)
        else $error("trip without start");
    start_block_a: assert property ((start_out & blocked_out) == 0)
        else $error("start and blocked together");
    ev_flags_a: assert property (event_valid |-> event_flags != 0)
        else $error("empty event");
    ev_start_a: assert property ($rose(start_out[0]) |->
        event_valid && event_stage == 2'h0 && event_flags[0])
        else $error("start on event missing");
    ev_trip_a: assert property ($rose(trip_out[0]) |->
        event_valid && event_flags[2]) else $error("trip on event missing");
endmodule : pwr_props
bind power_stage_block_event_logic pwr_props chk_u (.*);

/* File: dv/pwr_far_model.sv */
/* far side: blocking matrix, power samples and a time source counting aclk cycles
   assumes commands from the bench on aclk */
`timescale 1ns/1ps
module pwr_far_model
    import pwr_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [NSTAGE-1:0]    blk_cmd,
    input  wire logic [NSTAGE*PW-1:0] pwr_cmd,
    output logic [NSTAGE-1:0]         block_in,
    output logic [NSTAGE*PW-1:0]      meas_power,
    output logic [31:0]               time_stamp
);
    // matrix and samples follow commands, time runs on
    always_ff @(posedge aclk) begin
        block_in   <= blk_cmd;
        meas_power <= pwr_cmd;
        time_stamp <= aresetn ? time_stamp + 32'h1 : 32'h0;
    end
endmodule : pwr_far_model

/* File: dv/power_stage_block_event_logic_tb_top.sv */
/* bench for the power stage block
   assumes a 25 ns aclk and a 20-clock processing cycle */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module power_stage_block_event_logic_tb_top;
    import pwr_pkg::*;
    localparam int TCK = 20;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic event_valid, ta, tw, tb, tc, tr;
    logic [31:0] event_time;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, time_stamp, x = 32'h3C;
    logic [3:0] wstrb = 4'hF, blk_cmd = 0, block_in, start_out, trip_out;
    logic [3:0] blocked_out;
    logic [1:0] bresp, rresp, event_stage;
    logic [63:0] meas_power, pwr_cmd = 0;
    logic [5:0] event_flags;
    logic [33:0] rq[$], exp_r;
    logic [1:0] bq[$], exp_b;
    int n_errors = 0, checked = 0, cyc = 0;
    power_stage_block_event_logic #(.CYCLE_CLKS(TCK)) dut_u (.*);
    pwr_far_model far_u (.*);
    always #12.5 aclk = ~aclk;
    // copy of the processing cycle count, tick where it wraps
    always @(posedge aclk) cyc <= (!aresetn || cyc == TCK - 1) ? 0 : cyc + 1;
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    // n ticks, then on to mid-cycle where every stage has settled
    task automatic tk(input int n);
        int lim = (n + 1) * TCK;
        for (int j = 0; j < lim && (n > 0 || cyc != 10); j++) begin
            @(posedge aclk);
            if (cyc == TCK - 1) n--;
        end
        if (n > 0 || cyc != 10) begin
            n_errors++;
            stop_test();
        end
    endtask : tk
    // one register access, each channel released when taken
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [1:0] r);
        int i;
        if (w) begin
            bq.push_back(r);
            awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        end else begin
            rq.push_back({r, d});
            araddr <= a; arvalid <= 1; rready <= 1;
        end
        for (i = 0; i < 40; i++) begin
            @(negedge aclk);
            if (!(awvalid | wvalid | bready | arvalid | rready)) break;
            ta = awvalid & awready; tw = wvalid & wready; tb = bvalid & bready;
            tc = arvalid & arready; tr = rvalid & rready;
            @(posedge aclk);
            if (ta) awvalid <= 0; if (tw) wvalid <= 0; if (tb) bready <= 0;
            if (tc) arvalid <= 0; if (tr) rready <= 0;
        end
        @(posedge aclk);
        if (i == 40) begin
            n_errors++;
            stop_test();
        end
    endtask : bus
    task automatic stop_test;
        n_errors += rq.size() + bq.size();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    // answers compared with the oldest note
    always @(negedge aclk) begin
        if (rvalid && rready) begin
            exp_r = rq.pop_front();
            `CHK({rresp, rdata}, exp_r)
        end
        if (bvalid && bready) begin
            exp_b = bq.pop_front();
            `CHK(bresp, exp_b)
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        bus(0, A_CTRL, 32'h30, RESP_OKAY);
        bus(0, A_OPDLY, 32'h14, RESP_OKAY);
        bus(0, A_RELDLY, 32'h4, RESP_OKAY);
        bus(0, 8'h60, 32'h0, RESP_SLVERR);
        bus(1, 8'h60, 32'h1, RESP_SLVERR);
        bus(1, A_PICKUP, 32'h64, RESP_OKAY);
        bus(1, A_OPDLY, 32'h3, RESP_OKAY);
        for (int s = 0; s < 4; s++) begin
            x = xs(x);
            pwr_cmd[16*s +: 16] <= (s == 3) ? {10'h0, x[5:0]}
                                            : 16'h00C8 + {8'h00, x[7:0]};
        end
        blk_cmd <= 4'h2;
        tk(2);
        `CHK({trip_out[0], start_out[2:0]}, 4'h5)
        blk_cmd <= 4'h6;
        tk(6);
        `CHK({trip_out[1:0], start_out[1:0], blocked_out[1:0]}, 6'h16)
        `CHK({trip_out[3:2], start_out[3:2]}, 4'h0)
        bus(0, A_CNT0, 32'h401, RESP_OKAY);
        bus(0, A_CNT0 + 8'h04, 32'h0010_0000, RESP_OKAY);
        bus(1, A_CNTCLR, 32'h1, RESP_OKAY);
        bus(0, A_CNT0, 32'h0, RESP_OKAY);
        pwr_cmd[15:0] <= 16'h0062;
        tk(4);
        `CHK(trip_out[0], 1'b1)
        pwr_cmd[15:0] <= 16'h0061;
        tk(2);
        `CHK({start_out[0], trip_out[0]}, 2'h0)
        tk(5);
        `CHK(start_out[0], 1'b0)
        for (int v = 1; v < 4; v++) begin
            bus(1, A_CTRL, 32'h31 | (v << 1), RESP_OKAY);
            tk(2);
            `CHK(v == 1 ? start_out : v == 2 ? trip_out : blocked_out, 4'hF)
        end
        bus(1, A_CTRL, 32'h30, RESP_OKAY);
        bus(0, A_RECSEL, 32'hC0, RESP_OKAY);
        bus(0, A_REC_D, 32'h1C, RESP_OKAY);
        tk(2);
        stop_test();
    end
endmodule : power_stage_block_event_logic_tb_top
